// [bench/mlx_exec_checker.sv]
// concurrent checks on the move block ports
`timescale 1ns/1ps
module mlx_exec_checker (
	// clock and reset
	input wire CLK_SYS,
	input wire RESET,
	// bus handshakes
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire [1:0] S_AXI_BRESP,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// core outputs
	input wire DST_VALID,
	input wire [15:0] DST_ADDR,
	input wire GLOBAL_IRQ_ENABLE,
	input wire [14:0] PC_OUT
);
	// ------------
	// properties
	// ------------
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);
	sequence s_rd_take;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	sequence s_wr_take;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	chk_read_answer: assert property (s_rd_take |=> S_AXI_RVALID)
		else $error("read answer missing");
	chk_write_answer: assert property (s_wr_take |-> ##[1:4] S_AXI_BVALID)
		else $error("write answer missing");
	chk_resp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
		S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
	chk_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
		S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
	chk_store_pulse: assert property (DST_VALID |=> !DST_VALID)
		else $error("store pulse too long");
	chk_store_cause: assert property (DST_VALID |-> $rose(S_AXI_BVALID))
		else $error("store without a write");
	chk_addr_kept: assert property (!DST_VALID |->
		$stable(DST_ADDR) || DST_ADDR == 16'h0000) else $error("store address moved");
	chk_reset_idle: assert property ($fell(RESET) |-> !DST_VALID &&
		!GLOBAL_IRQ_ENABLE && PC_OUT == 15'h0000 && !S_AXI_BVALID) else $error("not idle");
	chk_irq_enable: assert property ($rose(GLOBAL_IRQ_ENABLE) |->
		S_AXI_BVALID || $past(S_AXI_BVALID)) else $error("enable without a write");
endmodule
bind mlx_exec mlx_exec_checker u_chk (.*);

// [bench/testbench.sv]
// self-checking bench for the literal and indirect move block
`timescale 1ns/1ps
`include "mlx_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
	logic CLK_SYS = 1'h0;
	logic RESET = 1'h1;
	logic [11:0] S_AXI_AWADDR = 12'h000;
	logic [11:0] S_AXI_ARADDR = 12'h000;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0] S_AXI_WSTRB = 4'hF;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic DST_VALID, GLOBAL_IRQ_ENABLE;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [31:0] S_AXI_RDATA, q;
	logic [1:0] r;
	logic [15:0] DST_ADDR, dst_a;
	logic [7:0] DST_DATA, dst_d;
	logic [14:0] PC_OUT;
	int n_fail, n_compared, n_dst, c;
	mlx_exec u_mlx_exec (.*);
	always #2 CLK_SYS = ~CLK_SYS;
	always @(posedge CLK_SYS)
	if (DST_VALID)
	begin
		n_dst++;
		dst_a = DST_ADDR;
		dst_d = DST_DATA;
	end
	// ------------
	// bus tasks
	// ------------
	task wr(input [11:0] a, input [31:0] d, input [1:0] e);
		logic done;
		done = 1'h0;
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		while (!done)
		begin
			@(posedge CLK_SYS);
			if (S_AXI_AWREADY)
				S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WREADY)
				S_AXI_WVALID <= 1'h0;
			if (S_AXI_BVALID)
			begin
				S_AXI_BREADY <= 1'h0;
				done = 1'h1;
				`CHK(S_AXI_BRESP, e)
			end
		end
		@(posedge CLK_SYS);
	endtask
	task rd(input [11:0] a);
		logic done;
		done = 1'h0;
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		while (!done)
		begin
			@(posedge CLK_SYS);
			if (S_AXI_ARREADY)
				S_AXI_ARVALID <= 1'h0;
			if (S_AXI_RVALID)
			begin
				S_AXI_RREADY <= 1'h0;
				q = S_AXI_RDATA;
				r = S_AXI_RRESP;
				done = 1'h1;
			end
		end
		@(posedge CLK_SYS);
	endtask
	task rc(input [11:0] a, input [31:0] e);
		rd(a);
		`CHK(q, e)
	endtask
	task ex(input [3:0] op, input [15:0] k);
		wr(`MLX_OFS_INSTR, {12'h000, op, k}, `MLX_RESP_OKAY);
	endtask
	// ------------
	// scenarios
	// ------------
	task t_reset;
		rc(`MLX_OFS_POWER_CTRL_REG, 32'h1);
		rc(`MLX_OFS_ACC, 32'h0);
		rd(12'h100);
		`CHK(r, `MLX_RESP_SLVERR)
		`CHK(q, 32'h0)
		wr(12'h100, 32'h0, `MLX_RESP_SLVERR);
		$display("t_reset done");
	endtask
	task t_lit;
		wr(`MLX_OFS_FLAGS, 32'hA5, `MLX_RESP_OKAY);
		ex(4'h1, 16'h001F);
		rc(`MLX_OFS_BANK, 32'h1F);
		ex(4'h2, 16'h007F);
		rc(`MLX_OFS_PAGE, 32'h7F);
		ex(4'h3, 16'h00FF);
		rc(`MLX_OFS_ACC, 32'hFF);
		c = n_dst;
		ex(4'h0, 16'h0055);
		rc(`MLX_OFS_ACC, 32'hFF);
		rc(`MLX_OFS_BANK, 32'h1F);
		`CHK(n_dst, c)
		ex(4'h3, 16'h004F);
		ex(4'h4, 16'h007F);
		rc(12'h3FC, 32'h4F);
		rc(`MLX_OFS_FLAGS, 32'hA5);
		$display("t_lit done");
	endtask
	task t_ind;
		logic [15:0] s, nw;
		logic [11:0] pa;
		logic [5:0] k;
		ex(4'h3, 16'h003C);
		for (int m = 0; m < 4; m++)
		begin
			s = m[0] ? 16'h0000 : 16'hFFFF;
			nw = m[0] ? s - 16'h0001 : s + 16'h0001;
			pa = m[0] ? `MLX_OFS_PTR1 : `MLX_OFS_PTR0;
			wr(pa, {16'h0000, s}, `MLX_RESP_OKAY);
			c = n_dst;
			ex(4'h5, {7'h00, m[0], 6'h00, m[1:0]});
			`CHK(n_dst, c + 1)
			`CHK(dst_a, m[1] ? s : nw)
			`CHK(dst_d, 8'h3C)
			rc(pa, {16'h0000, nw});
		end
		wr(`MLX_OFS_PTR0, 32'h10, `MLX_RESP_OKAY);
		for (int i = 0; i < 2; i++)
		begin
			k = i ? 6'h1F : 6'h20;
			c = n_dst;
			ex(4'h6, {10'h000, k});
			`CHK(n_dst, c + 1)
			`CHK(dst_a, i ? 16'h002F : 16'hFFF0)
			rc(`MLX_OFS_PTR0, 32'h10);
		end
		wr(`MLX_OFS_PTR1, 32'hABCD, `MLX_RESP_OKAY);
		ex(4'h4, 16'h0001);
		`CHK(dst_a, 16'hABCD)
		ex(4'h4, 16'h0000);
		`CHK(dst_a, 16'h0010)
		rc(`MLX_OFS_PTR1, 32'hABCD);
		rc(`MLX_OFS_FLAGS, 32'hA5);
		$display("t_ind done");
	endtask
	task t_soft;
		ex(4'h7, 16'h0000);
		rc(`MLX_OFS_POWER_CTRL_REG, 32'h0);
		rc(`MLX_OFS_ACC, 32'h0);
		rc(`MLX_OFS_BANK, 32'h0);
		rc(`MLX_OFS_PTR0, 32'h0);
		$display("t_soft done");
	endtask
	task t_irq;
		wr(`MLX_OFS_PUSH, 32'h1234, `MLX_RESP_OKAY);
		`CHK(GLOBAL_IRQ_ENABLE, 1'h0)
		ex(4'h8, 16'h0000);
		`CHK(PC_OUT, 15'h1234)
		`CHK(GLOBAL_IRQ_ENABLE, 1'h1)
		rc(`MLX_OFS_STATE, 32'h2);
		$display("t_irq done");
	endtask
	task print_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge CLK_SYS);
		RESET <= 1'h0;
		@(posedge CLK_SYS);
		t_reset;
		t_lit;
		t_ind;
		t_soft;
		t_irq;
		print_verdict;
	end
	initial
	begin
		#20000;
		n_fail++;
		print_verdict;
	end
endmodule

// [hw/mlx_defs.vh]
// constants for the literal / indirect move execution block
`ifndef MLX_DEFS_VH
`define MLX_DEFS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define MLX_OFS_INSTR 12'h000
`define MLX_OFS_STATE 12'h004
`define MLX_OFS_ACC 12'h008
`define MLX_OFS_BANK 12'h00C
`define MLX_OFS_PAGE 12'h010
`define MLX_OFS_PTR0 12'h014
`define MLX_OFS_PTR1 12'h018
`define MLX_OFS_PC 12'h01C
`define MLX_OFS_PUSH 12'h020
`define MLX_OFS_POWER_CTRL_REG 12'h024
`define MLX_OFS_FLAGS 12'h028
// file array window: 0x200 + 4*index
`define MLX_FILE_BASE_HI 3'h1
// ---------------------------------------------------------------
// instruction word fields
// ---------------------------------------------------------------
`define MLX_OP_MSB 19
`define MLX_OP_LSB 16
`define MLX_IND_SEL_BIT 8
`define MLX_OP_NO_OP 4'h0
`define MLX_OP_BANK 4'h1
`define MLX_OP_PAGE 4'h2
`define MLX_OP_ACC 4'h3
`define MLX_OP_FILE 4'h4
`define MLX_OP_IND_MODE 4'h5
`define MLX_OP_IND_REL 4'h6
`define MLX_OP_SOFT_RESET 4'h7
`define MLX_OP_RETURN_IRQ 4'h8
// pointer_mode_code values
`define MLX_MODE_PRE_INC 2'h0
`define MLX_MODE_PRE_DEC 2'h1
`define MLX_MODE_POST_INC 2'h2
`define MLX_MODE_POST_DEC 2'h3
// file addresses of indirect_window_0 and indirect_window_1
`define MLX_WINDOW0_ADDR 7'h00
`define MLX_WINDOW1_ADDR 7'h01
// ---------------------------------------------------------------
// reset values and bus answers
// ---------------------------------------------------------------
`define MLX_RST_BYTE 8'h00
`define MLX_RST_PTR 16'h0000
`define MLX_RST_PC 15'h0000
`define MLX_RST_SOFT_FLAG 1'b1
`define MLX_RESP_OKAY 2'h0
`define MLX_RESP_SLVERR 2'h2
`endif

// [hw/mlx_exec.v]
// execution unit for literal loads, file store, indirect store, reset and irq return
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Summary of operation
// RL1: bank-load puts a 5-bit literal into bank_select_register, flags untouched.
// RL2: page-load puts a 7-bit literal into pc_high_latch, flags untouched.
// RL3: acc-load puts an 8-bit literal into the accumulator in one cycle, flags untouched.
// RL4: file store copies the accumulator to the 7-bit addressed file register in one cycle.
// RL5: an access to indirect_window_n really goes to the address held in pointer n. Only the file store does so; bus accesses to file index 0/1 use file_mem.
// RL6: pointer_mode_code 00/01/10/11 selects pre-inc, pre-dec, post-inc, post-dec.
// RL7: relative form stores at pointer plus signed offset -32..31 and keeps the pointer.
// RL8: after an indirect store the pointer is old+1, old-1 or unchanged by mode.
// RL9: pointers are 16 bits and wrap modulo 65536 on increment and decrement.
// RL10: indirect stores and their pointer updates leave every status flag alone.
// RL11: soft reset does a full core reset and clears soft_reset_flag in power_ctrl_reg.
// RL12: return_from_irq pops stack_top into the pc, sets global_irq_enable, over two cycles.
// ---------------------------------------------------------------
`include "mlx_defs.vh"

module mlx_exec #(
	parameter STACK_DEPTH = 16,
	parameter STACK_AW = 4
)(
	// clock and reset
	input wire CLK_SYS,
	input wire RESET,
	// axi4-lite write address
	input wire [11:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	// axi4-lite write data
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	// axi4-lite write response
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// axi4-lite read
	input wire [11:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	// data-space store port for indirect stores
	output reg DST_VALID,
	output reg [15:0] DST_ADDR,
	output reg [7:0] DST_DATA,
	// core state
	output reg GLOBAL_IRQ_ENABLE,
	output reg [14:0] PC_OUT
);
	// ---------------------------------------------------------------
	// helpers and state
	// ---------------------------------------------------------------
	function [15:0] add16;
		input [15:0] a;
		input [15:0] b;
		add16 = a + b;
	endfunction
	function mapped;
		input [11:0] a;
		mapped = (a[11:9] == `MLX_FILE_BASE_HI) || ({a[11:2], 2'h0} <= `MLX_OFS_FLAGS);
	endfunction
	reg [7:0] acc_reg;
	reg [4:0] bank_select_register;
	reg [6:0] pc_high_latch;
	reg [15:0] ptr0_reg;
	reg [15:0] ptr1_reg;
	reg [7:0] flags_reg;
	reg soft_reset_flag;
	reg sreset_reg;
	reg irq_ret_reg;
	reg [14:0] stack_top [0:STACK_DEPTH-1];
	reg [STACK_AW-1:0] sp_reg;
	reg [7:0] file_mem [0:127];
	reg [11:0] awaddr_reg;
	reg aw_have_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_have_reg;
	wire core_rst = RESET | sreset_reg;
	wire do_wr = aw_have_reg & w_have_reg & ~S_AXI_BVALID & ~irq_ret_reg & ~sreset_reg;
	wire wr_map = mapped(awaddr_reg);
	wire full_word = (wstrb_reg == 4'hF);
	wire issue = do_wr & (awaddr_reg == `MLX_OFS_INSTR) & full_word;
	wire [3:0] op = wdata_reg[`MLX_OP_MSB:`MLX_OP_LSB];
	wire [7:0] lit = wdata_reg[7:0];
	wire ind_sel = wdata_reg[`MLX_IND_SEL_BIT];
	wire [1:0] mode_code = wdata_reg[1:0];
	wire [15:0] ptr_cur = ind_sel ? ptr1_reg : ptr0_reg;
	wire [15:0] ptr_inc = add16(ptr_cur, 16'h0001);
	wire [15:0] ptr_dec = add16(ptr_cur, 16'hFFFF);
	wire [15:0] rel_ofs = {{10{wdata_reg[5]}}, wdata_reg[5:0]};
	wire [STACK_AW-1:0] sp_dec = sp_reg - {{(STACK_AW-1){1'b0}}, 1'b1};
	// indirect address and pointer update
	reg [15:0] ind_addr;
	reg [15:0] ind_ptr_next;
	always @*
	begin
		ind_addr = ptr_cur;
		ind_ptr_next = ptr_cur;
		if (op == `MLX_OP_IND_REL)
			// RL7 offset, pointer kept
			ind_addr = add16(ptr_cur, rel_ofs);
		else
		begin
			// RL6 mode decode
			case (mode_code)
				`MLX_MODE_PRE_INC, `MLX_MODE_POST_INC:
					ind_ptr_next = ptr_inc;
				default:
					ind_ptr_next = ptr_dec;
			endcase
			// pre modes store at the updated pointer
			if (~mode_code[1])
				ind_addr = ind_ptr_next;
		end
	end
	// ---------------------------------------------------------------
	// axi4-lite write channel and power control flag
	// ---------------------------------------------------------------
	always @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `MLX_RESP_OKAY;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end
		else
		begin
			S_AXI_AWREADY <= ~aw_have_reg & ~(S_AXI_AWVALID & S_AXI_AWREADY);
			S_AXI_WREADY <= ~w_have_reg & ~(S_AXI_WVALID & S_AXI_WREADY);
			if (S_AXI_AWVALID & S_AXI_AWREADY)
			begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= {S_AXI_AWADDR[11:2], 2'h0};
			end
			if (S_AXI_WVALID & S_AXI_WREADY)
			begin
				w_have_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
			end
			if (do_wr)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_map ? `MLX_RESP_OKAY : `MLX_RESP_SLVERR;
			end
			else if (S_AXI_BVALID & S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end
	// power control flag, survives the soft reset
	always @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			soft_reset_flag <= `MLX_RST_SOFT_FLAG;
			sreset_reg <= 1'b0;
		end
		else
		begin
			sreset_reg <= issue & (op == `MLX_OP_SOFT_RESET);
			// RL11 clear flag, reset core
			if (issue & (op == `MLX_OP_SOFT_RESET))
				soft_reset_flag <= 1'b0;
			else if (do_wr & (awaddr_reg == `MLX_OFS_POWER_CTRL_REG) & wstrb_reg[0])
				soft_reset_flag <= wdata_reg[0];
		end
	end
	// ---------------------------------------------------------------
	// core execution
	// ---------------------------------------------------------------
	always @(posedge CLK_SYS)
	begin
		if (core_rst)
		begin
			acc_reg <= `MLX_RST_BYTE;
			bank_select_register <= 5'h00;
			pc_high_latch <= 7'h00;
			ptr0_reg <= `MLX_RST_PTR;
			ptr1_reg <= `MLX_RST_PTR;
			flags_reg <= `MLX_RST_BYTE;
			PC_OUT <= `MLX_RST_PC;
			GLOBAL_IRQ_ENABLE <= 1'b0;
			irq_ret_reg <= 1'b0;
			sp_reg <= {STACK_AW{1'b0}};
			DST_VALID <= 1'b0;
			DST_ADDR <= `MLX_RST_PTR;
			DST_DATA <= `MLX_RST_BYTE;
		end
		else
		begin
			DST_VALID <= 1'b0;
			irq_ret_reg <= 1'b0;
			// RL12 second cycle
			if (irq_ret_reg)
				GLOBAL_IRQ_ENABLE <= 1'b1;
			if (issue)
			begin
				case (op)
					`MLX_OP_BANK:
						// RL1 bank literal
						bank_select_register <= lit[4:0];
					`MLX_OP_PAGE:
						// RL2 page literal
						pc_high_latch <= lit[6:0];
					`MLX_OP_ACC:
						// RL3 acc literal
						acc_reg <= lit;
					`MLX_OP_FILE:
					begin
						// RL5 window redirect
						if (lit[6:0] == `MLX_WINDOW0_ADDR || lit[6:0] == `MLX_WINDOW1_ADDR)
						begin
							DST_VALID <= 1'b1;
							DST_ADDR <= lit[0] ? ptr1_reg : ptr0_reg;
							DST_DATA <= acc_reg;
						end
					end
					`MLX_OP_IND_MODE, `MLX_OP_IND_REL:
					begin
						// RL10 flags untouched here
						DST_VALID <= 1'b1;
						DST_ADDR <= ind_addr;
						DST_DATA <= acc_reg;
						// RL8 RL9 pointer update wraps
						if (ind_sel)
							ptr1_reg <= ind_ptr_next;
						else
							ptr0_reg <= ind_ptr_next;
					end
					`MLX_OP_RETURN_IRQ:
					begin
						// RL12 pop into pc
						PC_OUT <= stack_top[sp_dec];
						sp_reg <= sp_dec;
						irq_ret_reg <= 1'b1;
					end
					default: ;
				endcase
			end
			else if (do_wr)
			begin
				case (awaddr_reg)
					`MLX_OFS_ACC:
						if (wstrb_reg[0])
							acc_reg <= wdata_reg[7:0];
					`MLX_OFS_PTR0:
						ptr0_reg <= {wstrb_reg[1] ? wdata_reg[15:8] : ptr0_reg[15:8],
							wstrb_reg[0] ? wdata_reg[7:0] : ptr0_reg[7:0]};
					`MLX_OFS_PTR1:
						ptr1_reg <= {wstrb_reg[1] ? wdata_reg[15:8] : ptr1_reg[15:8],
							wstrb_reg[0] ? wdata_reg[7:0] : ptr1_reg[7:0]};
					`MLX_OFS_PC:
						if (full_word)
							PC_OUT <= wdata_reg[14:0];
					`MLX_OFS_PUSH:
						if (full_word)
							sp_reg <= sp_reg + {{(STACK_AW-1){1'b0}}, 1'b1};
					`MLX_OFS_FLAGS:
						if (wstrb_reg[0])
							flags_reg <= wdata_reg[7:0];
					`MLX_OFS_STATE:
						if (wstrb_reg[0])
							GLOBAL_IRQ_ENABLE <= wdata_reg[1];
					default: ;
				endcase
			end
		end
	end
	// file array and stack storage
	always @(posedge CLK_SYS)
	begin
		// RL4 acc to file
		if (issue & (op == `MLX_OP_FILE) & (lit[6:1] != 6'h00))
			file_mem[lit[6:0]] <= acc_reg;
		else if (do_wr & (awaddr_reg[11:9] == `MLX_FILE_BASE_HI) & wstrb_reg[0])
			file_mem[awaddr_reg[8:2]] <= wdata_reg[7:0];
		if (do_wr & ~core_rst & (awaddr_reg == `MLX_OFS_PUSH) & full_word)
			stack_top[sp_reg] <= wdata_reg[14:0];
	end
	// ---------------------------------------------------------------
	// axi4-lite read channel
	// ---------------------------------------------------------------
	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h00000000;
		case ({S_AXI_ARADDR[11:2], 2'h0})
			`MLX_OFS_STATE:
				rd_mux = {16'h0000, flags_reg, 6'h00, GLOBAL_IRQ_ENABLE, irq_ret_reg};
			`MLX_OFS_ACC: rd_mux = {24'h000000, acc_reg};
			`MLX_OFS_BANK: rd_mux = {27'h0000000, bank_select_register};
			`MLX_OFS_PAGE: rd_mux = {25'h0000000, pc_high_latch};
			`MLX_OFS_PTR0: rd_mux = {16'h0000, ptr0_reg};
			`MLX_OFS_PTR1: rd_mux = {16'h0000, ptr1_reg};
			`MLX_OFS_PC: rd_mux = {17'h00000, PC_OUT};
			`MLX_OFS_POWER_CTRL_REG: rd_mux = {31'h00000000, soft_reset_flag};
			`MLX_OFS_FLAGS: rd_mux = {24'h000000, flags_reg};
			default:
				if (S_AXI_ARADDR[11:9] == `MLX_FILE_BASE_HI)
					rd_mux = {24'h000000, file_mem[S_AXI_ARADDR[8:2]]};
		endcase
	end
	always @(posedge CLK_SYS)
	begin
		if (RESET)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `MLX_RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= ~S_AXI_RVALID & ~(S_AXI_ARVALID & S_AXI_ARREADY);
			if (S_AXI_ARVALID & S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_mux;
				S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `MLX_RESP_OKAY : `MLX_RESP_SLVERR;
			end
			else if (S_AXI_RVALID & S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end
endmodule
